// file: rtl/emp_pkg.sv
// Package: address map, bank layout and timing constants of the external memory port
package emp_pkg;
   localparam int NUM_BANKS = 4;
   localparam logic [31:0] ASYNC_B0_LO = 32'h0020_0000;
   localparam logic [31:0] ASYNC_B0_HI = 32'h007F_FFFF;
   localparam logic [31:0] ASYNC_B1_LO = 32'h0400_0000;
   localparam logic [31:0] ASYNC_B1_HI = 32'h047F_FFFF;
   localparam logic [31:0] ASYNC_B2_LO = 32'h0800_0000;
   localparam logic [31:0] ASYNC_B2_HI = 32'h087F_FFFF;
   localparam logic [31:0] ASYNC_B3_LO = 32'h0C00_0000;
   localparam logic [31:0] ASYNC_B3_HI = 32'h0C7F_FFFF;
   localparam logic [31:0] SDRAM_B0_LO = 32'h0020_0000;
   localparam logic [31:0] SDRAM_B0_HI = 32'h03FF_FFFF;
   localparam logic [31:0] SDRAM_B1_LO = 32'h0400_0000;
   localparam logic [31:0] SDRAM_B1_HI = 32'h07FF_FFFF;
   localparam logic [31:0] SDRAM_B2_LO = 32'h0800_0000;
   localparam logic [31:0] SDRAM_B2_HI = 32'h0BFF_FFFF;
   localparam logic [31:0] SDRAM_B3_LO = 32'h0C00_0000;
   localparam logic [31:0] SDRAM_B3_HI = 32'h0FFF_FFFF;
   localparam logic [31:0] FETCH_FULL_LO = 32'h0020_0000;
   localparam logic [31:0] FETCH_FULL_HI = 32'h005F_FFFF;
   localparam logic [31:0] FETCH_COMP_LO = 32'h0060_0000;
   localparam logic [31:0] FETCH_COMP_HI = 32'h00FF_FFFF;
   localparam int BANK_MSB = 27;
   localparam int BANK_LSB = 26;
   // Size code n selects 4 MB << n, codes 0..6 give 4 MB..256 MB
   localparam logic [2:0] SIZE_CODE_MAX = 3'h6;
   localparam logic [31:0] SIZE_4MB_WORDS = 32'h0010_0000;
   // Register offsets (byte addresses)
   localparam logic [11:0] REG_CTRL = 12'h000;
   localparam logic [11:0] REG_SDTIM = 12'h004;
   localparam logic [11:0] REG_STATUS = 12'h008;
   localparam logic [11:0] REG_ATIM0 = 12'h010;
   localparam logic [11:0] REG_ATIM_LAST = 12'h01C;
   localparam logic [11:0] REG_SDSIZE = 12'h020;
   // CTRL field layout
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_BUF_BIT = 4;
   localparam int CTRL_DMA_PRI_BIT = 5;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // Async timing: wait states [7:0], setup [11:8], hold [15:12]
   localparam logic [31:0] ATIM_RESET = 32'h0000_1103;
   // SDRAM timing: CAS latency [3:0], row precharge [7:4], row to column [11:8]
   localparam logic [31:0] SDTIM_RESET = 32'h0000_0323;
   localparam logic [31:0] SDSIZE_RESET = 32'h0000_6666;
   localparam logic [7:0] BUF_EXTRA_CYC = 8'h01;
   typedef enum logic [1:0] {REQ_READ, REQ_WRITE, REQ_FETCH} emp_kind_type;
endpackage : emp_pkg

// file: rtl/emp_bank_decode.sv
// Module: window decode of one external memory bank
`timescale 1ns/1ns
module emp_bank_decode
(
   input wire logic [31:0] addr_in,
   input wire logic [31:0] async_lo_in,
   input wire logic [31:0] async_hi_in,
   input wire logic [31:0] sdram_lo_in,
   input wire logic [2:0] size_code_in,
   input wire logic sdram_mode_in,
   output logic hit_out,
   output logic [31:0] offset_out
);
   import emp_pkg::*;
   logic [31:0] span;
   always_comb
   begin
      span = SIZE_4MB_WORDS << size_code_in;
      offset_out = addr_in - (sdram_mode_in ? sdram_lo_in : async_lo_in);
      // Windows are never compacted; the offset is the raw distance from the window base
      if (sdram_mode_in)
      begin
         hit_out = (addr_in >= sdram_lo_in) && (addr_in < sdram_lo_in + span);
      end
      else
      begin
         hit_out = (addr_in >= async_lo_in) && (addr_in <= async_hi_in);
      end
   end
endmodule : emp_bank_decode

// file: rtl/emp_port.sv
// Module: external memory port top, arbiter, decode, timing sequencer and APB registers
// Behaviour
// - Four banks, each configurable as async static memory or SDRAM.
// - Async windows: 6M words bank 0, 8M words banks 1 to 3.
// - Async decode ranges per bank as in the async address table.
// - SDRAM decode ranges per bank as in the SDRAM address table.
// - SDRAM addresses up to 62M words bank 0, 64M others.
// - Arbitrate core against DMA; one transfer at a time.
// - One select line per bank, four in all.
// - Async controller uses per-bank timing set of the accessed bank.
// - No remapping of partially populated windows; gaps stay gaps.
// - SDRAM bank size configurable from 4 MB to 256 MB.
// - SDRAM timing parameters are programmable.
// - SIMD access moves 64 bits for both processing elements.
// - Compressed and full-width instruction fetch supported.
// - Instruction fetch only from bank 0.
// - Full-width fetch and compressed fetch use their own bank 0 ranges.
// - Selectable external buffer timing mode adds a cycle per access.
// - Compressed fetch and SIMD apply to SDRAM banks only.
//
// The APB register port and the register offsets were decided locally.
`timescale 1ns/1ns
module emp_port
(
   input wire logic clk_in,
   input wire logic rst_in,
   // APB
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [11:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   // Core request
   input wire logic core_req_in,
   input wire logic [31:0] core_addr_in,
   input wire emp_pkg::emp_kind_type core_kind_in,
   input wire logic core_simd_in,
   input wire logic [63:0] core_wdata_in,
   output logic core_done_out,
   output logic core_err_out,
   // DMA request
   input wire logic dma_req_in,
   input wire logic [31:0] dma_addr_in,
   input wire logic dma_write_in,
   input wire logic [63:0] dma_wdata_in,
   output logic dma_done_out,
   output logic dma_err_out,
   output logic [63:0] rdata_out,
   output logic fetch_compressed_out,
   // Memory pins
   input wire logic [63:0] ext_port_data_bus_in,
   output logic [63:0] ext_port_data_bus_out,
   output logic ext_port_data_bus_oe_out,
   output logic [25:0] mem_addr_out,
   output logic [3:0] bank_select_lines_n_out,
   output logic mem_we_n_out,
   output logic mem_oe_n_out,
   output logic sdram_cmd_out
);
   import emp_pkg::*;

   // ****************
   // Registers
   // ****************
   logic [31:0] ctrl_q;
   logic [31:0] sdtim_q;
   logic [31:0] sdsize_q;
   logic [31:0] atim_q [NUM_BANKS];
   logic [63:0] pins_meta_q;
   logic [63:0] pins_sync_q;
   logic busy_q;
   logic [1:0] bank_q;
   logic owner_dma_q;
   logic last_dma_q;
   logic [7:0] count_q;
   logic [7:0] count_d;
   logic sd_mode_hit;
   logic [31:0] xfer_count_q;

   wire apb_acc = psel_in && penable_in;
   wire apb_wr = apb_acc && pwrite_in;
   wire [11:0] atim_idx_w = (paddr_in - REG_ATIM0) >> 2;
   wire atim_range = (paddr_in >= REG_ATIM0) && (paddr_in <= REG_ATIM_LAST);

   // Bank modes: one bit per bank, 1 = SDRAM
   wire [3:0] bank_sdram = ctrl_q[CTRL_MODE_LSB +: NUM_BANKS];

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         ctrl_q <= CTRL_RESET;
         sdtim_q <= SDTIM_RESET;
         sdsize_q <= SDSIZE_RESET;
      end
      else if (apb_wr)
      begin
         if (paddr_in == REG_CTRL)
         begin
            ctrl_q <= pwdata_in;
         end
         if (paddr_in == REG_SDTIM)
         begin
            sdtim_q <= pwdata_in;
         end
         if (paddr_in == REG_SDSIZE)
         begin
            sdsize_q <= pwdata_in;
         end
      end
   end

   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         for (int i = 0; i < NUM_BANKS; i++)
         begin
            atim_q[i] <= ATIM_RESET;
         end
      end
      else if (apb_wr && atim_range)
      begin
         atim_q[atim_idx_w[1:0]] <= pwdata_in;
      end
   end

   // Zero wait-state slave; unmapped addresses answer with pslverr
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         prdata_out <= 32'h0000_0000;
         pready_out <= 1'b0;
         pslverr_out <= 1'b0;
      end
      else
      begin
         pready_out <= psel_in && !penable_in;
         pslverr_out <= 1'b0;
         prdata_out <= 32'h0000_0000;
         if (psel_in && !penable_in)
         begin
            if (paddr_in == REG_CTRL)
               prdata_out <= ctrl_q;
            else if (paddr_in == REG_SDTIM)
               prdata_out <= sdtim_q;
            else if (paddr_in == REG_SDSIZE)
               prdata_out <= sdsize_q;
            else if (paddr_in == REG_STATUS)
               prdata_out <= {xfer_count_q[28:0], owner_dma_q, bank_q[0], busy_q};
            else if (atim_range)
               prdata_out <= atim_q[atim_idx_w[1:0]];
            else
               pslverr_out <= 1'b1;
         end
      end
   end

   // ****************
   // Data pin synchroniser
   // ****************
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         pins_meta_q <= 64'h0000_0000_0000_0000;
         pins_sync_q <= 64'h0000_0000_0000_0000;
      end
      else
      begin
         pins_meta_q <= ext_port_data_bus_in;
         pins_sync_q <= pins_meta_q;
      end
   end

   // ****************
   // Arbitration and decode
   // ****************
   // Round robin when DMA priority bit clear, else DMA always wins
   wire pick_dma = dma_req_in && (!core_req_in || ctrl_q[CTRL_DMA_PRI_BIT] || !last_dma_q);
   wire [31:0] req_addr = pick_dma ? dma_addr_in : core_addr_in;
   wire req_fetch = !pick_dma && core_kind_in == REQ_FETCH;
   wire req_write = pick_dma ? dma_write_in : core_kind_in == REQ_WRITE;
   wire req_simd = !pick_dma && core_simd_in;
   wire [1:0] req_bank = req_addr[BANK_MSB:BANK_LSB];
   wire [31:0] lo_a [NUM_BANKS] = '{ASYNC_B0_LO, ASYNC_B1_LO, ASYNC_B2_LO, ASYNC_B3_LO};
   wire [31:0] hi_a [NUM_BANKS] = '{ASYNC_B0_HI, ASYNC_B1_HI, ASYNC_B2_HI, ASYNC_B3_HI};
   wire [31:0] lo_s [NUM_BANKS] = '{SDRAM_B0_LO, SDRAM_B1_LO, SDRAM_B2_LO, SDRAM_B3_LO};
   logic [3:0] hit;
   logic [31:0] offs [NUM_BANKS];

   for (genvar b = 0; b < NUM_BANKS; b++)
   begin : g_bank
      emp_bank_decode u_dec
      (
         .addr_in(req_addr),
         .async_lo_in(lo_a[b]),
         .async_hi_in(hi_a[b]),
         .sdram_lo_in(lo_s[b]),
         .size_code_in((sdsize_q[4*b +: 3] > SIZE_CODE_MAX) ? SIZE_CODE_MAX : sdsize_q[4*b +: 3]),
         .sdram_mode_in(bank_sdram[b]),
         .hit_out(hit[b]),
         .offset_out(offs[b])
      );
   end

   // SDRAM bank 0 cap of 62M words falls out of its window base
   assign sd_mode_hit = bank_sdram[req_bank];
   wire fetch_full = req_addr >= FETCH_FULL_LO && req_addr <= FETCH_FULL_HI;
   wire fetch_comp = req_addr >= FETCH_COMP_LO && req_addr <= FETCH_COMP_HI;
   // Fetch: bank 0 only, compressed range needs SDRAM
   wire fetch_ok = req_bank == 2'h0 && (fetch_full || (fetch_comp && sd_mode_hit));
   // SIMD needs an SDRAM bank
   wire req_ok = hit[req_bank] && (!req_fetch || fetch_ok) && (!req_simd || sd_mode_hit);
   wire req_any = core_req_in || dma_req_in;
   // A request is held until its done pulse is seen; taking it again in that cycle would run it twice
   wire done_shown = core_done_out || dma_done_out;
   wire start = !busy_q && req_any && !done_shown;

   // Access length: per-bank async timing or programmable SDRAM timing, plus buffer mode
   always_comb
   begin
      if (sd_mode_hit)
         count_d = {4'h0, sdtim_q[3:0]} + {4'h0, sdtim_q[7:4]} + {4'h0, sdtim_q[11:8]};
      else
         count_d = atim_q[req_bank][7:0] + {4'h0, atim_q[req_bank][11:8]} + {4'h0, atim_q[req_bank][15:12]};
      if (ctrl_q[CTRL_BUF_BIT])
         count_d = count_d + BUF_EXTRA_CYC;
   end

   // ****************
   // Transfer sequencer
   // ****************
   logic kind_write_q;
   logic sd_q;
   logic simd_q;
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         busy_q <= 1'b0;
         bank_q <= 2'h0;
         owner_dma_q <= 1'b0;
         last_dma_q <= 1'b0;
         count_q <= 8'h00;
         kind_write_q <= 1'b0;
         sd_q <= 1'b0;
         simd_q <= 1'b0;
         xfer_count_q <= 32'h0000_0000;
         bank_select_lines_n_out <= 4'hF;
         mem_addr_out <= 26'h000_0000;
         mem_we_n_out <= 1'b1;
         mem_oe_n_out <= 1'b1;
         sdram_cmd_out <= 1'b0;
         ext_port_data_bus_out <= 64'h0000_0000_0000_0000;
         ext_port_data_bus_oe_out <= 1'b0;
         fetch_compressed_out <= 1'b0;
      end
      else if (start && req_ok)
      begin
         busy_q <= 1'b1;
         bank_q <= req_bank;
         owner_dma_q <= pick_dma;
         last_dma_q <= pick_dma;
         count_q <= count_d;
         kind_write_q <= req_write;
         sd_q <= sd_mode_hit;
         simd_q <= req_simd;
         xfer_count_q <= xfer_count_q + 32'h0000_0001;
         bank_select_lines_n_out <= ~(4'h1 << req_bank);
         mem_addr_out <= offs[req_bank][25:0];
         mem_we_n_out <= !req_write;
         mem_oe_n_out <= req_write;
         sdram_cmd_out <= sd_mode_hit;
         // Upper lane carries the secondary element word only on core SIMD; DMA writes drive all 64 bits
         ext_port_data_bus_out <= pick_dma ? dma_wdata_in : (req_simd ? core_wdata_in : {32'h0, core_wdata_in[31:0]});
         ext_port_data_bus_oe_out <= req_write;
         fetch_compressed_out <= req_fetch && fetch_comp;
      end
      else if (busy_q)
      begin
         if (count_q == 8'h00)
         begin
            busy_q <= 1'b0;
            bank_select_lines_n_out <= 4'hF;
            mem_we_n_out <= 1'b1;
            mem_oe_n_out <= 1'b1;
            sdram_cmd_out <= 1'b0;
            ext_port_data_bus_oe_out <= 1'b0;
            // Compressed-fetch level ends with its transfer
            fetch_compressed_out <= 1'b0;
         end
         else
         begin
            count_q <= count_q - 8'h01;
         end
      end
   end

   // ****************
   // Completion
   // ****************
   // Completion pulses; a refused request finishes at once with an error
   always_ff @(posedge clk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         core_done_out <= 1'b0;
         dma_done_out <= 1'b0;
         core_err_out <= 1'b0;
         dma_err_out <= 1'b0;
         rdata_out <= 64'h0000_0000_0000_0000;
      end
      else
      begin
         core_done_out <= 1'b0;
         dma_done_out <= 1'b0;
         core_err_out <= 1'b0;
         dma_err_out <= 1'b0;
         if (start && !req_ok)
         begin
            core_done_out <= !pick_dma;
            dma_done_out <= pick_dma;
            core_err_out <= !pick_dma;
            dma_err_out <= pick_dma;
         end
         else if (busy_q && count_q == 8'h00)
         begin
            core_done_out <= !owner_dma_q;
            dma_done_out <= owner_dma_q;
            if (!kind_write_q)
               // Only a SIMD access on an SDRAM bank returns the secondary element word
               rdata_out <= (sd_q && simd_q) ? pins_sync_q : {32'h0, pins_sync_q[31:0]};
         end
      end
   end
endmodule : emp_port

// file: tb/emp_port_props.sv
// Checker: port-level assertions of the external memory port
`timescale 1ns/1ns
module emp_port_props
(
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pready_out,
   input wire logic core_req_in,
   input wire logic [31:0] core_addr_in,
   input wire logic dma_req_in,
   input wire logic core_done_out,
   input wire logic core_err_out,
   input wire logic dma_done_out,
   input wire logic fetch_compressed_out,
   input wire logic [3:0] bank_select_lines_n_out,
   input wire logic mem_we_n_out,
   input wire logic mem_oe_n_out
);
   wire [3:0] sel = ~bank_select_lines_n_out;
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (rst_in);
   // ****************************************
   // Properties
   // ****************************************
   one_select_a: assert property ($onehot0(sel)) else $error("two bank selects low");
   core_bank_a: assert property (core_req_in && !dma_req_in && sel != 4'h0 |->
      sel == (4'h1 << core_addr_in[27:26])) else $error("select of wrong bank");
   fetch_bank_a: assert property (fetch_compressed_out |-> sel[3:1] == 3'h0) else $error("fetch off bank 0");
   err_nosel_a: assert property (core_err_out |-> sel == 4'h0 && $past(sel) == 4'h0)
      else $error("select during refused access");
   err_done_a: assert property (core_err_out |-> core_done_out) else $error("error without done");
   one_dir_a: assert property (!(!mem_we_n_out && !mem_oe_n_out)) else $error("write and read strobes together");
   one_done_a: assert property (!(core_done_out && dma_done_out)) else $error("two transfers ended at once");
   apb_answer_a: assert property (psel_in && !penable_in |=> pready_out) else $error("no ready after setup");
   apb_pulse_a: assert property (pready_out |=> !pready_out) else $error("ready held too long");
   sel_hold_a: assert property ($rose(|sel) |=> $stable(sel)) else $error("select dropped early");
   done_pulse_a: assert property (core_done_out || dma_done_out |=> !core_done_out && !dma_done_out)
      else $error("done pulse longer than one cycle");
endmodule : emp_port_props
bind emp_port emp_port_props u_props (.clk_in, .rst_in, .psel_in, .penable_in, .pready_out, .core_req_in,
   .core_addr_in, .dma_req_in, .core_done_out, .core_err_out, .dma_done_out, .fetch_compressed_out,
   .bank_select_lines_n_out, .mem_we_n_out, .mem_oe_n_out);

// file: tb/emp_mem_model.sv
// Partner model: external memory that answers reads and captures writes
`timescale 1ns/1ns
module emp_mem_model
(
   input wire logic clk_in,
   input wire logic [3:0] sel_n_in,
   input wire logic oe_n_in,
   input wire logic we_n_in,
   input wire logic [25:0] addr_in,
   input wire logic [63:0] data_in,
   output logic [63:0] data_out,
   output logic [63:0] last_wr_out
);
   logic [63:0] hold_q = 64'h0;
   // ****************************************
   // Bus
   // ****************************************
   // Released bus toggles so stale data never passes for an answer
   always @(posedge clk_in)
   begin
      hold_q <= data_out;
      if (!we_n_in && sel_n_in != 4'hF)
         last_wr_out <= data_in;
   end
   // Two narrow words side by side, never one wide part
   assign data_out = (!oe_n_in && sel_n_in != 4'hF) ? {6'h0, ~addr_in, 6'h0, addr_in} : ~hold_q;
endmodule : emp_mem_model

// file: tb/emp_port_tb.sv
// Testbench: random and corner accesses through the external memory port
`timescale 1ns/1ns
module emp_port_tb;
   import emp_pkg::*;
   logic clk_in = 0, rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0, pready_out, pslverr_out;
   logic core_req_in = 0, core_simd_in = 0, dma_req_in = 0, dma_write_in = 0, core_done_out, core_err_out;
   logic dma_done_out, dma_err_out, fetch_compressed_out, oe, we_n, oe_n, cmd, buf_on, err_seen, fc_seen, sv, s;
   logic oe_seen, cmd_seen;
   logic [11:0] paddr_in = 12'h000;
   logic [31:0] pwdata_in = 32'h0, prdata_out, core_addr_in = 32'h0, dma_addr_in = 32'h0, a, lo, hi, rv;
   logic [63:0] core_wdata_in = 64'h0, dma_wdata_in = 64'h0, rdata_out, bus_in, bus_out, last_wr, rd_seen, wd;
   emp_kind_type core_kind_in = REQ_READ, k;
   logic [25:0] mem_addr_out, addr_seen;
   logic [3:0] sel_n, sel_seen, mode;
   logic [31:0] atim [4], sdtim, sdsize;
   logic [11:0] ra [5] = '{12'h000, 12'h004, 12'h010, 12'h01C, 12'h020};
   logic [31:0] re [5] = '{32'h0, 32'h323, 32'h1103, 32'h1103, 32'h6666};
   logic [31:0] ca [6] = '{32'h005F_FFFF, 32'h0060_0000, 32'h00FF_FFFF, 32'h0100_0000, 32'h0400_0000, 32'h1000_0000};
   int errors = 0, check_count = 0, cycles = 0, cnt, b;
   integer seed = 32'hed93d9ce;
   always #10 clk_in = ~clk_in;
   emp_port dut (.clk_in, .rst_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
      .pready_out, .pslverr_out, .core_req_in, .core_addr_in, .core_kind_in, .core_simd_in, .core_wdata_in,
      .core_done_out, .core_err_out, .dma_req_in, .dma_addr_in, .dma_write_in, .dma_wdata_in, .dma_done_out,
      .dma_err_out, .rdata_out, .fetch_compressed_out, .ext_port_data_bus_in(bus_in), .ext_port_data_bus_out(bus_out),
      .ext_port_data_bus_oe_out(oe), .mem_addr_out, .bank_select_lines_n_out(sel_n), .mem_we_n_out(we_n),
      .mem_oe_n_out(oe_n), .sdram_cmd_out(cmd));
   emp_mem_model mem (.clk_in, .sel_n_in(sel_n), .oe_n_in(oe_n), .we_n_in(we_n), .addr_in(mem_addr_out),
      .data_in(bus_out), .data_out(bus_in), .last_wr_out(last_wr));
   // ****************************************
   // Helpers
   // ****************************************
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : finish_test
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   always @(posedge clk_in)
   begin
      cycles <= cycles + 1;
      if (cycles == 40000)
      begin
         errors = errors + 1;
         finish_test();
      end
   end
   always @(posedge clk_in)
      if (core_req_in && sel_n != 4'hF)
      begin
         cnt <= cnt + 1;
         sel_seen <= ~sel_n;
         addr_seen <= mem_addr_out;
         fc_seen <= fc_seen | fetch_compressed_out;
         oe_seen <= oe;
         cmd_seen <= cmd;
      end
   task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
      @(posedge clk_in);
      psel_in <= 1'b1;
      pwrite_in <= wr;
      paddr_in <= ad;
      pwdata_in <= d;
      @(posedge clk_in);
      penable_in <= 1'b1;
      do @(posedge clk_in); while (pready_out !== 1'b1);
      rv = prdata_out;
      sv = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
   endtask : apb
   task automatic mem_op(input logic [31:0] ad, input emp_kind_type kd, input logic sm, input logic [63:0] dd);
      @(posedge clk_in);
      core_req_in <= 1'b1;
      core_addr_in <= ad;
      core_kind_in <= kd;
      core_simd_in <= sm;
      core_wdata_in <= dd;
      cnt = 0;
      fc_seen = 0;
      do @(posedge clk_in); while (core_done_out !== 1'b1);
      err_seen = core_err_out;
      rd_seen = rdata_out;
      core_req_in <= 1'b0;
   endtask : mem_op
   function automatic logic ok_of(input logic [31:0] ad, input emp_kind_type kd, input logic sm);
      int bb;
      logic sd;
      bb = ad[27:26];
      sd = mode[bb];
      lo = (bb == 0) ? 32'h0020_0000 : {4'h0, ad[27:26], 26'h0};
      hi = {4'h0, ad[27:26], 26'h0} + (sd ? 32'h03FF_FFFF : 32'h007F_FFFF);
      if (sd && lo + (SIZE_4MB_WORDS << sdsize[4 * bb +: 3]) - 1 < hi)
         hi = lo + (SIZE_4MB_WORDS << sdsize[4 * bb +: 3]) - 1;
      if (ad[31:28] != 4'h0 || ad < lo || ad > hi || (sm && !sd))
         return 1'b0;
      if (kd == REQ_FETCH)
         return bb == 0 && ad <= 32'h00FF_FFFF && (sd || ad <= 32'h005F_FFFF);
      return 1'b1;
   endfunction : ok_of
   function automatic int n_of(input int bb);
      logic [31:0] t;
      t = mode[bb] ? sdtim : atim[bb];
      return (mode[bb] ? t[3:0] + t[7:4] + t[11:8] : t[7:0] + t[11:8] + t[15:12]) + buf_on + 1;
   endfunction : n_of
   task automatic run(input logic [31:0] ad, input emp_kind_type kd, input logic sm);
      logic ok;
      logic [25:0] off;
      wd = {$random(seed), $random(seed)};
      mem_op(ad, kd, sm, wd);
      ok = ok_of(ad, kd, sm);
      off = ad - lo;
      check(err_seen, !ok);
      if (ok)
      begin
         check(sel_seen, 4'h1 << ad[27:26]);
         check(addr_seen, off);
         check(cnt, n_of(ad[27:26]));
         check(fc_seen, kd == REQ_FETCH && ad >= 32'h0060_0000);
         check(cmd_seen, mode[ad[27:26]]);
         check(oe_seen, kd == REQ_WRITE);
         if (kd == REQ_READ)
            check(rd_seen, sm ? {6'h0, ~off, 6'h0, off} : {38'h0, off});
         if (kd == REQ_WRITE)
            check(sm ? last_wr : last_wr[31:0], sm ? wd : wd[31:0]);
      end
   endtask : run
   task automatic setup_banks();
      mode = $random(seed);
      buf_on = $random(seed);
      sdsize = 32'h0;
      sdtim = 32'h0000_0011 + ($random(seed) & 32'h0000_0322);
      // Wait count kept at two or more: read data needs two cycles through the pin synchroniser
      for (int i = 0; i < 4; i++)
      begin
         atim[i] = 32'h0000_0002 + ($random(seed) & 32'h0000_3306);
         sdsize[4 * i +: 4] = $unsigned($random(seed)) % 7;
         apb(1'b1, REG_ATIM0 + 12'(4 * i), atim[i]);
      end
      apb(1'b1, REG_CTRL, {27'h0, buf_on, mode});
      apb(1'b1, REG_SDTIM, sdtim);
      apb(1'b1, REG_SDSIZE, sdsize);
      apb(1'b0, REG_SDSIZE, 32'h0);
      check(rv, sdsize);
   endtask : setup_banks
   initial
   begin
      repeat (5) @(posedge clk_in);
      rst_in <= 1'b0;
      foreach (ra[i])
      begin
         apb(1'b0, ra[i], 32'h0);
         check({sv, rv}, {1'b0, re[i]});
      end
      apb(1'b0, 12'h0FC, 32'h0);
      check({sv, rv}, 33'h1_0000_0000);
      $display("test registers done");
      for (int p = 0; p < 3; p++)
      begin
         setup_banks();
         // Code corners sit apart from the data addresses used below
         foreach (ca[i])
            run(ca[i], i < 5 ? REQ_FETCH : REQ_READ, 1'b0);
         for (int j = 0; j < 20; j++)
         begin
            b = $unsigned($random(seed)) % 4;
            void'(ok_of({4'h0, 2'(b), 26'h0}, REQ_READ, 1'b0));
            case ($unsigned($random(seed)) % 4)
               0: a = lo - 1;
               1: a = hi;
               2: a = hi + 1;
               default: a = lo + $unsigned($random(seed)) % (hi - lo);
            endcase
            k = emp_kind_type'($unsigned($random(seed)) % 3);
            s = (k != REQ_FETCH) && $random(seed);
            run(a, k, s);
         end
         $display("test pass %0d done", p);
      end
      fork
         mem_op(32'h0400_0010, REQ_READ, 1'b0, 64'h0);
         begin
            @(posedge clk_in);
            dma_req_in <= 1'b1;
            dma_addr_in <= 32'h0800_0020;
            dma_write_in <= 1'b1;
            dma_wdata_in <= 64'h1234_5678;
            do @(posedge clk_in); while (dma_done_out !== 1'b1);
            check(dma_err_out, 1'b0);
            dma_req_in <= 1'b0;
         end
      join
      check(err_seen, 1'b0);
      check(rd_seen, 64'h10);
      check(last_wr[31:0], 32'h1234_5678);
      $display("test arbitration done");
      finish_test();
   end
endmodule : emp_port_tb
